// ===== rtl/pcw_params.svh
`ifndef PCW_PARAMS_SVH
`define PCW_PARAMS_SVH
// Trigger vector positions
`define PCW_TRG_AXIS      0
`define PCW_TRG_MSG       1
`define PCW_TRG_OVR       2
`define PCW_TRG_TOOLQ     3
`define PCW_TRG_KEY       4
`define PCW_TRG_SIG       5
`define PCW_TRG_TINFO     6
`define PCW_TRG_COUNT     7
// Word field layout
`define PCW_AXIS_BITS     5
`define PCW_LO_MSB        7
`define PCW_HI_LSB        8
`define PCW_WORD_MSB      15
`define PCW_SIG_HOLD_BIT  0
`define PCW_SIG_DONE_BIT  1
`define PCW_SIG_COMP_BIT  4
// Codes
`define PCW_OVR_KEEP      8'h00
`define PCW_OVR_RESET     8'h80
`define PCW_KBD_ENABLE    8'h00
`define PCW_KBD_DISABLE   8'hff
`define PCW_BYTE_ZERO     8'h00
`define PCW_WORD_ZERO     16'h0000
`define PCW_AXIS_NONE     5'h00
`endif

// ===== rtl/pcw_pkg.sv
package pcw_pkg;
  // Words as held by the far side
  typedef struct packed {
    logic [15:0] axis_inhibit_word;
    logic [15:0] message_error_word;
    logic [15:0] override_word;
    logic [15:0] tool_query_number;
    logic [15:0] key_simulation_word;
    logic [15:0] signal_word;
  } pcw_words_t;
  // Static controller settings
  typedef struct packed {
    logic message_source_select;
    logic inhibit_source_split;
    logic mst_passthrough_select;
    logic dual_compensation_enable;
  } pcw_cfg_t;
  typedef enum logic [2:0] {
    PCW_RUN   = 3'b001,
    PCW_DRAIN = 3'b010,
    PCW_HALT  = 3'b100
  } pcw_seq_t;
endpackage

// ===== rtl/pcw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcw_params.svh"
// Functional notes
// [RL1] Trigger activation applies its paired register
// [RL2] Bits 0-4 inhibit W,Z,Y,X,V axes
// [RL3] Block needing inhibited axis waits for release
// [RL4] Source 1: only flag marks raise messages
// [RL5] Source 0: instruction and word path only
// [RL6] Show latest number; delete key clears it (the code clears only with source select 0)
// [RL7] Far side: message number in low byte
// [RL8] Far side: error number in high byte
// [RL9] Override bytes coded; zero keeps present value
// [RL10] Tool query then info read returns data
// [RL11] One key code per key trigger
// [RL12] Upper byte 00 enables, ff disables keyboard
// [RL13] Far side re-enables keyboard when finished
// [RL14] Split: feed hold pin, transfer hold bit0
// [RL15] Hold low, no passthrough: finish then halt
// [RL16] Passthrough: run M/S/T-only blocks, then halt
// [RL17] Function done from bit1; holds active low
// [RL18] Dual compensation splits into two tables
// [RL19] Bit4 picks first or second table
// [RL20] Single or split tables, never both
// [RL21] One transfer per trigger activation
// [RL22] Undefined register bits are ignored
module pcw_top (
  input  wire logic               i_sys_clk,
  input  wire logic               i_arst_n,
  input  wire logic               i_clk_en,
  input  wire pcw_pkg::pcw_words_t i_words,
  input  wire logic [6:0]         i_triggers,
  input  wire pcw_pkg::pcw_cfg_t  i_cfg,
  input  wire logic               i_hold_pin_n,
  input  wire logic [4:0]         i_block_axes,
  input  wire logic               i_block_active,
  input  wire logic               i_block_in_pos,
  input  wire logic               i_next_mst_only,
  input  wire logic               i_flag_msg_valid,
  input  wire logic [7:0]         i_flag_msg_num,
  input  wire logic               i_instr_msg_valid,
  input  wire logic [7:0]         i_instr_msg_num,
  input  wire logic               i_delete_key,
  input  wire logic [15:0]        i_tool_table_info,
  output logic [4:0]              o_axis_inhibit,
  output logic                    o_axis_wait,
  output logic [7:0]              o_msg_num,
  output logic [7:0]              o_err_num,
  output logic [7:0]              o_spindle_ovr,
  output logic [7:0]              o_feed_ovr,
  output logic [15:0]             o_tool_query_num,
  output logic                    o_tool_query_stb,
  output logic [15:0]             o_tool_info_word,
  output logic [7:0]              o_key_code,
  output logic                    o_key_stb,
  output logic                    o_keyboard_en,
  output logic                    o_feed_hold_n,
  output logic                    o_transfer_hold_n,
  output logic                    o_function_done,
  output logic                    o_comp_table_sel,
  output logic                    o_dual_comp_active,
  output logic                    o_exec_halt
);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger edge detection and pin synchroniser

  logic [6:0] trg_q, trg_d;
  logic [6:0] fire;
  logic       pin_m_q, pin_m_d, pin_s_q, pin_s_d;

  // A held flag must not re-apply its word every cycle
  always_comb begin
    trg_d   = i_triggers;
    fire    = i_triggers & ~trg_q;  // see [RL21]
    pin_m_d = i_hold_pin_n;
    pin_s_d = pin_m_q;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trg_q   <= 7'h00;
      pin_m_q <= 1'b1;
      pin_s_q <= 1'b1;
    end else if (i_clk_en) begin
      trg_q   <= trg_d;
      pin_m_q <= pin_m_d;
      pin_s_q <= pin_s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied words

  logic [4:0]  inh_q, inh_d;
  logic [7:0]  msg_q, msg_d, err_q, err_d, spd_q, spd_d, fed_q, fed_d;
  logic [15:0] tq_q, tq_d, ti_q, ti_d;
  logic        tqs_q, tqs_d, kst_q, kst_d, kbd_q, kbd_d;
  logic [7:0]  key_q, key_d;
  logic        lan_hold_q, lan_hold_d, lan_done_q, lan_done_d, sel_q, sel_d;
  logic [7:0]  wlo, whi, olo, ohi, klo, khi;
  logic        msg_path;

  always_comb begin
    wlo = i_words.message_error_word[`PCW_LO_MSB:0];
    whi = i_words.message_error_word[`PCW_WORD_MSB:`PCW_HI_LSB];
    olo = i_words.override_word[`PCW_LO_MSB:0];
    ohi = i_words.override_word[`PCW_WORD_MSB:`PCW_HI_LSB];
    klo = i_words.key_simulation_word[`PCW_LO_MSB:0];
    khi = i_words.key_simulation_word[`PCW_WORD_MSB:`PCW_HI_LSB];
    msg_path = !i_cfg.message_source_select;
    inh_d = inh_q;
    msg_d = msg_q;
    err_d = err_q;
    spd_d = spd_q;
    fed_d = fed_q;
    tq_d  = tq_q;
    tqs_d = 1'b0;
    ti_d  = ti_q;
    key_d = key_q;
    kst_d = 1'b0;
    kbd_d = kbd_q;
    lan_hold_d = lan_hold_q;
    lan_done_d = lan_done_q;
    sel_d = sel_q;
    if (fire[`PCW_TRG_AXIS]) begin
      // Upper bits carry nothing
      inh_d = i_words.axis_inhibit_word[`PCW_AXIS_BITS-1:0];  // see [RL2] see [RL22]
    end
    // Delete first so a new number in the same cycle survives
    if (msg_path && i_delete_key) begin
      msg_d = `PCW_BYTE_ZERO;  // see [RL6]
      err_d = `PCW_BYTE_ZERO;
    end
    if (msg_path && i_instr_msg_valid) begin
      msg_d = i_instr_msg_num;  // see [RL5]
      err_d = `PCW_BYTE_ZERO;
    end
    if (msg_path && fire[`PCW_TRG_MSG]) begin
      msg_d = wlo;  // see [RL1] see [RL6]
      err_d = whi;
    end
    if (!msg_path && i_flag_msg_valid) begin
      msg_d = i_flag_msg_num;  // see [RL4]
      err_d = `PCW_BYTE_ZERO;
    end
    if (fire[`PCW_TRG_OVR]) begin
      if (olo != `PCW_OVR_KEEP) spd_d = olo;  // see [RL9]
      if (ohi != `PCW_OVR_KEEP) fed_d = ohi;
    end
    if (fire[`PCW_TRG_TOOLQ]) begin
      tq_d  = i_words.tool_query_number;  // see [RL10]
      tqs_d = 1'b1;
    end
    if (fire[`PCW_TRG_TINFO]) begin
      ti_d = i_tool_table_info;  // see [RL10]
    end
    if (fire[`PCW_TRG_KEY]) begin
      key_d = klo;  // see [RL11]
      kst_d = 1'b1;
      // Other upper codes leave the keyboard as it was
      if (khi == `PCW_KBD_ENABLE) kbd_d = 1'b1;  // see [RL12]
      else if (khi == `PCW_KBD_DISABLE) kbd_d = 1'b0;
    end
    if (fire[`PCW_TRG_SIG]) begin
      lan_hold_d = i_words.signal_word[`PCW_SIG_HOLD_BIT];  // see [RL14]
      lan_done_d = i_words.signal_word[`PCW_SIG_DONE_BIT];  // see [RL17]
      sel_d      = i_words.signal_word[`PCW_SIG_COMP_BIT];  // see [RL19]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      inh_q      <= `PCW_AXIS_NONE;
      msg_q      <= `PCW_BYTE_ZERO;
      err_q      <= `PCW_BYTE_ZERO;
      spd_q      <= `PCW_OVR_RESET;
      fed_q      <= `PCW_OVR_RESET;
      tq_q       <= `PCW_WORD_ZERO;
      tqs_q      <= 1'b0;
      ti_q       <= `PCW_WORD_ZERO;
      key_q      <= `PCW_BYTE_ZERO;
      kst_q      <= 1'b0;
      kbd_q      <= 1'b1;
      lan_hold_q <= 1'b1;
      lan_done_q <= 1'b1;
      sel_q      <= 1'b0;
    end else if (i_clk_en) begin
      inh_q      <= inh_d;
      msg_q      <= msg_d;
      err_q      <= err_d;
      spd_q      <= spd_d;
      fed_q      <= fed_d;
      tq_q       <= tq_d;
      tqs_q      <= tqs_d;
      ti_q       <= ti_d;
      key_q      <= key_d;
      kst_q      <= kst_d;
      kbd_q      <= kbd_d;
      lan_hold_q <= lan_hold_d;
      lan_done_q <= lan_done_d;
      sel_q      <= sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold routing, compensation select and block sequencing

  pcw_pkg::pcw_seq_t st_q, st_d;
  logic xfer_hold_n, done_in;
  logic wait_q, wait_d, halt_q, halt_d, fh_q, fh_d, th_q, th_d, fd_q, fd_d;
  logic cs_q, cs_d, dc_q, dc_d;

  // Without the split the one pin serves all three signals
  always_comb begin
    xfer_hold_n = i_cfg.inhibit_source_split ? lan_hold_q : pin_s_q;  // see [RL14]
    done_in     = i_cfg.inhibit_source_split ? lan_done_q : pin_s_q;  // see [RL17]
    fh_d = pin_s_q;
    th_d = xfer_hold_n;
    fd_d = done_in;
    // Single-table mode pins the select to the first set
    dc_d = i_cfg.dual_compensation_enable;  // see [RL18]
    cs_d = i_cfg.dual_compensation_enable & sel_q;  // see [RL20]
    wait_d = i_block_active && ((i_block_axes & inh_d) != `PCW_AXIS_NONE);  // see [RL3]
    st_d = st_q;
    unique case (st_q)
      pcw_pkg::PCW_RUN: begin
        if (!xfer_hold_n) st_d = i_block_active ? pcw_pkg::PCW_DRAIN : pcw_pkg::PCW_HALT;
      end
      pcw_pkg::PCW_DRAIN: begin
        if (xfer_hold_n) st_d = pcw_pkg::PCW_RUN;
        else if (i_block_in_pos) st_d = pcw_pkg::PCW_HALT;  // see [RL15]
      end
      pcw_pkg::PCW_HALT: begin
        if (xfer_hold_n) st_d = pcw_pkg::PCW_RUN;
      end
      default: st_d = pcw_pkg::PCW_RUN;
    endcase
    // M/S/T-only blocks pass a hold when passthrough is set
    halt_d = (st_d == pcw_pkg::PCW_HALT) &&
             !(i_cfg.mst_passthrough_select && i_next_mst_only);  // see [RL16]
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q   <= pcw_pkg::PCW_RUN;
      wait_q <= 1'b0;
      halt_q <= 1'b0;
      fh_q   <= 1'b1;
      th_q   <= 1'b1;
      fd_q   <= 1'b1;
      cs_q   <= 1'b0;
      dc_q   <= 1'b0;
    end else if (i_clk_en) begin
      st_q   <= st_d;
      wait_q <= wait_d;
      halt_q <= halt_d;
      fh_q   <= fh_d;
      th_q   <= th_d;
      fd_q   <= fd_d;
      cs_q   <= cs_d;
      dc_q   <= dc_d;
    end
  end

  // Outputs straight from flops
  assign o_axis_inhibit     = inh_q;
  assign o_axis_wait        = wait_q;
  assign o_msg_num          = msg_q;
  assign o_err_num          = err_q;
  assign o_spindle_ovr      = spd_q;
  assign o_feed_ovr         = fed_q;
  assign o_tool_query_num   = tq_q;
  assign o_tool_query_stb   = tqs_q;
  assign o_tool_info_word   = ti_q;
  assign o_key_code         = key_q;
  assign o_key_stb          = kst_q;
  assign o_keyboard_en      = kbd_q;
  assign o_feed_hold_n      = fh_q;
  assign o_transfer_hold_n  = th_q;
  assign o_function_done    = fd_q;
  assign o_comp_table_sel   = cs_q;
  assign o_dual_comp_active = dc_q;
  assign o_exec_halt        = halt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  a_axis_apply: assert property (i_clk_en && fire[0] |=> o_axis_inhibit ==  // see [RL2]
    $past(i_words.axis_inhibit_word[4:0])) else $error("axis word not applied");
  a_axis_hold: assert property (i_clk_en && !fire[0] |=> $stable(o_axis_inhibit))  // see [RL21]
    else $error("axis word changed without trigger");
  a_axis_wait: assert property (i_clk_en && i_block_active &&  // see [RL3]
    ((i_block_axes & o_axis_inhibit) != 5'h00) && !fire[0] |=> o_axis_wait)
    else $error("inhibited block not held");
  a_msg_blocked: assert property (i_clk_en && i_cfg.message_source_select &&  // see [RL4]
    !i_flag_msg_valid |=> $stable(o_msg_num) && $stable(o_err_num))
    else $error("message changed with flag source");
  a_msg_clear: assert property (i_clk_en && !i_cfg.message_source_select && i_delete_key &&  // see [RL6]
    !fire[1] && !i_instr_msg_valid |=> o_msg_num == 8'h00 && o_err_num == 8'h00)
    else $error("delete key did not clear");
  a_ovr_keep: assert property (i_clk_en && fire[2] && i_words.override_word[7:0] == 8'h00  // see [RL9]
    |=> $stable(o_spindle_ovr)) else $error("zero override changed value");
  a_key_pulse: assert property (i_clk_en && o_key_stb |=> !o_key_stb)  // see [RL11]
    else $error("key strobe longer than one cycle");
  a_kbd_lock: assert property (i_clk_en && fire[4] && i_words.key_simulation_word[15:8] ==  // see [RL12]
    8'hff |=> !o_keyboard_en) else $error("keyboard not disabled");
  a_comp_single: assert property (!o_dual_comp_active |-> !o_comp_table_sel)  // see [RL20]
    else $error("second table used in single mode");
  a_halt_drain: assert property (i_clk_en && st_q == pcw_pkg::PCW_DRAIN && !xfer_hold_n &&  // see [RL15]
    i_block_in_pos && !i_cfg.mst_passthrough_select |=> o_exec_halt)
    else $error("no halt after block finished");
  a_hold_route: assert property (i_clk_en && i_cfg.inhibit_source_split ##1  // see [RL14]
    i_clk_en && i_cfg.inhibit_source_split |=> o_transfer_hold_n == $past(lan_hold_q))
    else $error("transfer hold not from signal word");

  c_msg_post: cover property (fire[1] && !i_cfg.message_source_select);
  c_hold_halt: cover property (st_q == pcw_pkg::PCW_DRAIN ##[1:20] o_exec_halt);
  c_pass_mst: cover property (st_q == pcw_pkg::PCW_HALT && !o_exec_halt);
  c_tool_read: cover property (o_tool_query_stb ##[1:20] fire[6]);

endmodule
`default_nettype wire

// ===== bench/pcw_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far-side controller: holds the six words and raises one trigger at a time
module pcw_plc_model (
  input  wire logic                i_sys_clk,
  output wire pcw_pkg::pcw_words_t o_words,
  output logic [6:0]               o_triggers
);
  logic [15:0] w [6];
  // Known contents from time zero, no trigger active
  initial begin
    foreach (w[k]) w[k] = 16'h0000;
    o_triggers = 7'h00;
  end
  assign o_words = {w[0], w[1], w[2], w[3], w[4], w[5]};
  // Word lands an edge before its trigger rises; trigger is forced low first
  // so a held trigger still gets a fresh rising edge
  task automatic fire(input int idx, input logic [15:0] v, input bit keep = 1'b0);
    @(posedge i_sys_clk);
    if (idx < 6) w[idx] <= v;
    o_triggers[idx] <= 1'b0;
    @(posedge i_sys_clk);
    o_triggers[idx] <= 1'b1;
    @(posedge i_sys_clk);
    o_triggers[idx] <= keep;
  endtask
  // Contents change with no activation
  task automatic poke(input int idx, input logic [15:0] v);
    @(posedge i_sys_clk);
    w[idx] <= v;
  endtask
endmodule
`default_nettype wire

// ===== bench/plc_to_cnc_variable_write_bench.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module plc_to_cnc_variable_write_bench;
  logic clk, rst_n, hold_n, act, in_pos, mst, flag_v, instr_v, del;
  logic [4:0] axes;
  logic [7:0] flag_n, instr_n, message_instruction, err, spo, fdo, kc, sp_e, fd_e;
  logic [15:0] tinfo, tqn, tiw, v, ax;
  logic [4:0] inh;
  logic awt, tqs, ks, kbe, fh, th, fd, cs, da, hlt, kb_e;
  pcw_pkg::pcw_cfg_t cfg;
  wire pcw_pkg::pcw_words_t words;
  wire [6:0] trg;
  int error_cnt, n_tests;
  logic [31:0] st;
  logic [7:0] oc [6] = '{8'h80, 8'h40, 8'h20, 8'h01, 8'h00, 8'h80};
  logic [7:0] kh [4] = '{8'hff, 8'h5a, 8'h00, 8'hff};

  pcw_plc_model u_pcw_plc_model (.i_sys_clk(clk), .o_words(words), .o_triggers(trg));
  pcw_top u_pcw_top (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_clk_en(1'b1), .i_words(words),
    .i_triggers(trg), .i_cfg(cfg), .i_hold_pin_n(hold_n), .i_block_axes(axes),
    .i_block_active(act), .i_block_in_pos(in_pos), .i_next_mst_only(mst),
    .i_flag_msg_valid(flag_v), .i_flag_msg_num(flag_n), .i_instr_msg_valid(instr_v),
    .i_instr_msg_num(instr_n), .i_delete_key(del), .i_tool_table_info(tinfo),
    .o_axis_inhibit(inh), .o_axis_wait(awt), .o_msg_num(message_instruction), .o_err_num(err),
    .o_spindle_ovr(spo), .o_feed_ovr(fdo), .o_tool_query_num(tqn),
    .o_tool_query_stb(tqs), .o_tool_info_word(tiw), .o_key_code(kc), .o_key_stb(ks),
    .o_keyboard_en(kbe), .o_feed_hold_n(fh), .o_transfer_hold_n(th),
    .o_function_done(fd), .o_comp_table_sel(cs), .o_dual_comp_active(da),
    .o_exec_halt(hlt));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  // A zero byte keeps the present override
  function automatic logic [7:0] ovr(input logic [7:0] old, input logic [7:0] nw);
    return (nw == 8'h00) ? old : nw;
  endfunction
  // Only 00 and ff move the keyboard enable
  function automatic logic kbd(input logic old, input logic [7:0] hi);
    return (hi == 8'hff) ? 1'b0 : (hi == 8'h00) ? 1'b1 : old;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One-cycle pulse on flag, instruction or delete inputs
  task automatic strobe(input logic [2:0] s, input logic [7:0] n);
    @(posedge clk);
    {flag_v, instr_v, del} <= s;
    flag_n <= n;
    instr_n <= n;
    @(posedge clk);
    {flag_v, instr_v, del} <= 3'b000;
    @(negedge clk);
  endtask
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end

  // Main sequence
  initial begin
    {rst_n, act, in_pos, mst, flag_v, instr_v, del} = 7'h00;
    {hold_n, axes, flag_n, instr_n, tinfo, cfg} = {1'b1, 37'h0, 4'h0};
    {error_cnt, n_tests, st} = {32'd0, 32'd0, 32'd70747};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({spo, fdo}, 16'h8080);
    chk({kbe, th, fd, hlt}, 4'he);
    // Inhibit with a moving block; wait only when an inhibited axis is needed
    @(posedge clk) act <= 1'b1;
    repeat (8) begin
      v = 16'(rnd());
      ax = 16'(rnd());
      @(posedge clk) axes <= ax[4:0];
      u_pcw_plc_model.fire(0, v);
      @(negedge clk);
      chk(inh, v[4:0]);
      chk(awt, |(ax[4:0] & v[4:0]));
    end
    // Held trigger and later contents change nothing
    u_pcw_plc_model.fire(0, 16'h001f, 1'b1);
    u_pcw_plc_model.poke(0, 16'h0000);
    settle(3);
    chk(inh, 5'h1f);
    u_pcw_plc_model.fire(0, 16'h0000);
    @(negedge clk);
    chk({inh, awt}, 6'h00);
    // Message word path, source select 0
    repeat (6) begin
      v = 16'(rnd());
      u_pcw_plc_model.fire(1, v);
      @(negedge clk);
      chk({err, message_instruction}, v);
    end
    strobe(3'b100, 8'h42);
    chk(message_instruction, v[7:0]);
    strobe(3'b010, 8'h37);
    chk({err, message_instruction}, 16'h0037);
    strobe(3'b001, 8'h00);
    chk({err, message_instruction}, 16'h0000);
    // Source select 1: only flag marks count
    @(posedge clk) cfg.message_source_select <= 1'b1;
    u_pcw_plc_model.fire(1, 16'h1122);
    strobe(3'b010, 8'h55);
    chk({err, message_instruction}, 16'h0000);
    strobe(3'b100, 8'h66);
    strobe(3'b001, 8'h00);
    chk({err, message_instruction}, 16'h0066);
    @(posedge clk) cfg.message_source_select <= 1'b0;
    // Override codes, zero bytes in each half
    {sp_e, fd_e} = 16'h8080;
    for (int i = 0; i < 6; i++) begin
      v = {oc[(i + 2) % 6], oc[i]};
      u_pcw_plc_model.fire(2, v);
      @(negedge clk);
      sp_e = ovr(sp_e, v[7:0]);
      fd_e = ovr(fd_e, v[15:8]);
      chk({fdo, spo}, {fd_e, sp_e});
    end
    // Tool query then tool information read
    v = 16'(rnd());
    u_pcw_plc_model.fire(3, v);
    @(negedge clk);
    chk(tqs, 1'b1);
    chk(tqn, v);
    @(negedge clk);
    chk(tqs, 1'b0);
    ax = 16'(rnd());
    @(posedge clk) tinfo <= ax;
    u_pcw_plc_model.fire(6, 16'h0000);
    @(negedge clk);
    chk(tiw, ax);
    // Key codes with keyboard control bytes
    kb_e = 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = {kh[i], 8'(rnd())};
      u_pcw_plc_model.fire(4, v);
      @(negedge clk);
      kb_e = kbd(kb_e, v[15:8]);
      chk({ks, kc}, {1'b1, v[7:0]});
      chk(kbe, kb_e);
      @(negedge clk);
      chk(ks, 1'b0);
    end
    u_pcw_plc_model.fire(4, 16'h0000);
    @(negedge clk);
    chk(kbe, 1'b1);
    // Split holds, dual tables, block sequencing
    @(posedge clk) cfg <= 4'b0101;
    u_pcw_plc_model.fire(5, 16'h0010);
    settle(2);
    chk({th, fd, cs, da, hlt}, 5'b00110);
    @(posedge clk) in_pos <= 1'b1;
    @(posedge clk) in_pos <= 1'b0;
    settle(2);
    chk(hlt, 1'b1);
    @(posedge clk) {cfg.mst_passthrough_select, mst} <= 2'b11;
    settle(2);
    chk(hlt, 1'b0);
    @(posedge clk) mst <= 1'b0;
    settle(2);
    chk(hlt, 1'b1);
    u_pcw_plc_model.fire(5, 16'h0003);
    settle(3);
    chk({th, fd, hlt}, 3'b110);
    @(posedge clk) hold_n <= 1'b0;
    settle(4);
    chk({fh, th}, 2'b01);
    @(posedge clk) {hold_n, cfg.dual_compensation_enable} <= 2'b10;
    u_pcw_plc_model.fire(5, 16'h0013);
    settle(2);
    chk({cs, da}, 2'b00);
    // Mid-run reset: overrides and holds return to their idle levels
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({spo, fdo}, 16'h8080);
    chk({kbe, th, fd, hlt, cs, da}, 6'h38);
    summarize();
  end
endmodule
`default_nettype wire
